// ===== logic/mcuio_pkg.sv
// mcuio_pkg: register indices, reset values, field positions and bus answers of the i/o port block.
// assumes registers sit at byte address four times their index on a 32-bit AXI4-Lite slave.
package mcuio_pkg;

  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned IDX_LSB      = 2;
  localparam int unsigned IDX_MSB      = 9;

  // register indices; byte address is index times four
  localparam logic [7:0]  IDX_P0_DATA  = 8'hc0;
  localparam logic [7:0]  IDX_P0_DIR   = 8'hc1;
  localparam logic [7:0]  IDX_P2_DATA  = 8'hc4;
  localparam logic [7:0]  IDX_P2_DIR   = 8'hc5;
  localparam logic [7:0]  IDX_P3_DATA  = 8'hc6;
  localparam logic [7:0]  IDX_P4_DATA  = 8'hc8;
  localparam logic [7:0]  IDX_P5_DATA  = 8'hca;
  localparam logic [7:0]  IDX_ALT_SEL  = 8'hf4;
  localparam logic [7:0]  IDX_DISP_SEL = 8'hf5;
  localparam logic [7:0]  IDX_PU_ZERO  = 8'hfc;
  localparam logic [7:0]  IDX_PU_TWO   = 8'hfe;

  // reset values
  localparam logic [7:0]  RST_DIR      = 8'h00;
  localparam logic [7:0]  RST_LATCH    = 8'h00;
  localparam logic [7:0]  RST_P4       = 8'h00;
  localparam logic [7:0]  RST_ALT_SEL  = 8'h00;

  // alternate function select fields
  localparam int unsigned ALT_IRQ0_BIT = 0;
  localparam int unsigned ALT_IRQ1_BIT = 1;
  localparam int unsigned ALT_BUZ_BIT  = 2;
  localparam logic [7:0]  ALT_MASK     = 8'h1f;

  // display driver select fields
  localparam int unsigned DISP_P3_BIT  = 0;
  localparam int unsigned DISP_P4_BIT  = 1;
  localparam int unsigned DISP_P5_BIT  = 2;
  localparam logic [7:0]  DISP_MASK    = 8'h07;

  // pin positions of shared functions
  localparam int unsigned P0_BUZ_PIN   = 7;
  localparam int unsigned P0_CAP_PIN   = 2;
  localparam int unsigned P2_SERIAL_THREE_CLOCK_PIN  = 0;
  localparam int unsigned P2_SO3_PIN   = 1;
  localparam int unsigned P2_SO1_PIN   = 5;
  localparam int unsigned P2_SI1_PIN   = 6;
  localparam int unsigned P2_SERIAL_ONE_CLOCK_PIN  = 7;

  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  BYTE_ONES    = 8'hff;
  localparam logic [23:0] RDATA_PAD    = 24'h00_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

endpackage : mcuio_pkg

// ===== logic/mcuio_bidir_byte.sv
// mcuio_bidir_byte: pin steering of one eight-bit bidirectional port.
// assumes latch, direction and select come from flip-flops and pins are synchronous.
`timescale 1ns/100ps
module mcuio_bidir_byte (
  input  wire logic [7:0] latch_i,
  input  wire logic [7:0] dir_i,
  input  wire logic [7:0] pullup_sel_i,
  input  wire logic [7:0] alt_sel_i,
  input  wire logic [7:0] alt_out_i,
  input  wire logic [7:0] alt_oe_i,
  input  wire logic [7:0] pin_i,
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe_o,
  output logic      [7:0] pullup_en_o,
  output logic      [7:0] rd_o
);

  // a selected peripheral owns the pin whatever the direction bit says
  assign pin_oe_o    = (alt_sel_i & alt_oe_i) | (~alt_sel_i & dir_i);
  assign pin_o       = (alt_sel_i & alt_out_i) | (~alt_sel_i & latch_i);
  // pull-up only while the pin is not driven
  assign pullup_en_o = pullup_sel_i & ~pin_oe_o;
  assign rd_o        = (pin_i & ~dir_i) | (latch_i & dir_i);

endmodule : mcuio_bidir_byte

// ===== logic/mcuio_out_byte.sv
// mcuio_out_byte: one eight-bit output-only port with display driver alternate.
// assumes the display driver segment byte is synchronous to the system clock.
`timescale 1ns/100ps
module mcuio_out_byte (
  input  wire logic [7:0] latch_i,
  input  wire logic       disp_sel_i,
  input  wire logic [7:0] disp_i,
  output logic      [7:0] pin_o
);

  assign pin_o = disp_sel_i ? disp_i : latch_i;

endmodule : mcuio_out_byte

// ===== logic/mcuio_top.sv
// mcuio_top: general-purpose i/o ports 0, 2, 3, 4 and 5 with an AXI4-Lite register slave.
// assumes one 10 MHz clock, pins synchronous to it, peripherals and pad drivers outside.
//
// Overview of operation
// [R1] a direction bit at 1 drives its pin, at 0 the pin is input
// [R2] reset clears all direction registers so every bidirectional pin starts as input
// [R3] every port register accepts whole-byte writes and masked single-bit writes
// [R4] ports give output-only and bidirectional pins; port 6 lives in another block
// [R5] port 0 is bidirectional, data at index c0, direction at index c1
// [R6] port 0 pins carry interrupts, capture input, analog inputs and buzzer
// [R7] port 0 input pins get pull-ups bit by bit from pull-up select zero
// [R8] alternate select resets to zero; a 1 routes its peripheral to the pin
// [R9] buzzer and interrupt selects override the port 0 direction bit
// [R10] port 2 is bidirectional, data at index c4, direction at index c5
// [R11] port 2 pins carry serial three, analog inputs and serial one
// [R12] port 2 input pins get pull-ups bit by bit from pull-up select two
// [R13] port 3 is output only at index c6, display outputs 24 to 31 alternate
// [R14] port 4 is output only at index c8, reset 00, display outputs 32 to 39
// [R15] port 5 at index ca drives its latch value onto the pins
// [R16] software writes port 5 latch to 0 before reading pin levels
// [R17] port 5 resets to input, display outputs 40 to 47 alternate
// [R18] ports 0 and 2 read pin level on inputs and latch on outputs
`timescale 1ns/100ps
module mcuio_top (
  input  wire logic                          ref_clk_i,
  input  wire logic                          arst_n_i,
  // AXI4-Lite slave
  input  wire logic [mcuio_pkg::ADDR_W-1:0]  s_axi_awaddr_i,
  input  wire logic                          s_axi_awvalid_i,
  output logic                               s_axi_awready_o,
  input  wire logic [31:0]                   s_axi_wdata_i,
  input  wire logic [3:0]                    s_axi_wstrb_i,
  input  wire logic                          s_axi_wvalid_i,
  output logic                               s_axi_wready_o,
  output logic [1:0]                         s_axi_bresp_o,
  output logic                               s_axi_bvalid_o,
  input  wire logic                          s_axi_bready_i,
  input  wire logic [mcuio_pkg::ADDR_W-1:0]  s_axi_araddr_i,
  input  wire logic                          s_axi_arvalid_i,
  output logic                               s_axi_arready_o,
  output logic [31:0]                        s_axi_rdata_o,
  output logic [1:0]                         s_axi_rresp_o,
  output logic                               s_axi_rvalid_o,
  input  wire logic                          s_axi_rready_i,
  // pins
  input  wire logic [7:0]                    port0_pin_i,
  output logic      [7:0]                    port0_pin_o,
  output logic      [7:0]                    port0_pin_oe_o,
  output logic      [7:0]                    port0_pullup_en_o,
  input  wire logic [7:0]                    port2_pin_i,
  output logic      [7:0]                    port2_pin_o,
  output logic      [7:0]                    port2_pin_oe_o,
  output logic      [7:0]                    port2_pullup_en_o,
  output logic      [7:0]                    port3_pin_o,
  output logic      [7:0]                    port4_pin_o,
  input  wire logic [7:0]                    port5_pin_i,
  output logic      [7:0]                    port5_pin_o,
  output logic      [7:0]                    port5_pin_oe_o,
  // peripheral side
  output logic                               ext_irq_zero_pin_o,
  output logic                               ext_irq_one_pin_o,
  output logic                               remote_capture_pin_o,
  input  wire logic                          buzzer_out_pin_i,
  input  wire logic                          serial_three_en_i,
  input  wire logic                          serial_three_clock_drv_i,
  input  wire logic                          serial_three_clock_oe_i,
  output logic                               serial_three_clock_o,
  input  wire logic                          serial_three_out_i,
  input  wire logic                          serial_one_en_i,
  input  wire logic                          serial_one_out_i,
  output logic                               serial_one_in_o,
  input  wire logic                          serial_one_clock_drv_i,
  input  wire logic                          serial_one_clock_oe_i,
  output logic                               serial_one_clock_o,
  input  wire logic [23:0]                   display_driver_output_i,
  output logic      [7:0]                    alt_function_select_o
);

  typedef struct packed {
    logic [7:0] p0_data;
    logic [7:0] p0_dir;
    logic [7:0] p2_data;
    logic [7:0] p2_dir;
    logic [7:0] p3_data;
    logic [7:0] p4_data;
    logic [7:0] p5_data;
    logic [7:0] alt_sel;
    logic [7:0] pu_zero;
    logic [7:0] pu_two;
    logic [7:0] disp;
    logic       aw_got;
    logic       aw_ok;
    logic [7:0] aw_idx;
    logic       w_got;
    logic       w_en;
    logic [7:0] w_data;
    logic [7:0] w_mask;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic       wr_seen;
  } mcuio_state_s;

  localparam mcuio_state_s ST_RST = '{p0_dir:  mcuio_pkg::RST_DIR,
                                      p2_dir:  mcuio_pkg::RST_DIR,
                                      p0_data: mcuio_pkg::RST_LATCH,
                                      p2_data: mcuio_pkg::RST_LATCH,
                                      p3_data: mcuio_pkg::RST_LATCH,
                                      p4_data: mcuio_pkg::RST_P4,
                                      p5_data: mcuio_pkg::RST_LATCH,
                                      alt_sel: mcuio_pkg::RST_ALT_SEL,
                                      default: '0};

  mcuio_state_s st_r;
  mcuio_state_s st_nxt;

  logic       aw_fire;
  logic       w_fire;
  logic       ar_fire;
  logic       wr_fire;
  logic [7:0] ar_idx;
  logic       ar_ok;
  logic [7:0] p0_alt_sel;
  logic [7:0] p0_alt_out;
  logic [7:0] p0_alt_oe;
  logic [7:0] p2_alt_sel;
  logic [7:0] p2_alt_out;
  logic [7:0] p2_alt_oe;
  logic [7:0] p0_rd;
  logic [7:0] p2_rd;
  logic [7:0] p5_rd;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] dat, input logic [7:0] msk);
    merge = (old & ~msk) | (dat & msk);
  endfunction : merge

  assign s_axi_awready_o = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready_o  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready_o = !st_r.rvalid;
  assign aw_fire         = s_axi_awvalid_i && s_axi_awready_o;
  assign w_fire          = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_fire         = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_fire         = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign ar_idx          = s_axi_araddr_i[mcuio_pkg::IDX_MSB:mcuio_pkg::IDX_LSB];
  assign ar_ok           = (s_axi_araddr_i[mcuio_pkg::ADDR_W-1:mcuio_pkg::IDX_MSB+1] == '0);

  // port 0 alternates: interrupts forced to input, buzzer forced to output
  always_comb begin
    p0_alt_sel = mcuio_pkg::BYTE_ZERO;
    p0_alt_out = mcuio_pkg::BYTE_ZERO;
    p0_alt_oe  = mcuio_pkg::BYTE_ZERO;
    p0_alt_sel[mcuio_pkg::ALT_IRQ0_BIT]   = st_r.alt_sel[mcuio_pkg::ALT_IRQ0_BIT];   // R9
    p0_alt_sel[mcuio_pkg::ALT_IRQ1_BIT]   = st_r.alt_sel[mcuio_pkg::ALT_IRQ1_BIT];   // R9
    p0_alt_sel[mcuio_pkg::P0_BUZ_PIN]     = st_r.alt_sel[mcuio_pkg::ALT_BUZ_BIT];    // R9
    p0_alt_out[mcuio_pkg::P0_BUZ_PIN]     = buzzer_out_pin_i;                        // R6
    p0_alt_oe[mcuio_pkg::P0_BUZ_PIN]      = 1'b1;
  end

  // port 2 alternates: serial links own their pins while enabled
  always_comb begin
    p2_alt_sel = mcuio_pkg::BYTE_ZERO;
    p2_alt_out = mcuio_pkg::BYTE_ZERO;
    p2_alt_oe  = mcuio_pkg::BYTE_ZERO;
    p2_alt_sel[mcuio_pkg::P2_SERIAL_THREE_CLOCK_PIN] = serial_three_en_i;                          // R11
    p2_alt_sel[mcuio_pkg::P2_SO3_PIN]  = serial_three_en_i;
    p2_alt_out[mcuio_pkg::P2_SERIAL_THREE_CLOCK_PIN] = serial_three_clock_drv_i;
    p2_alt_oe[mcuio_pkg::P2_SERIAL_THREE_CLOCK_PIN]  = serial_three_clock_oe_i;
    p2_alt_out[mcuio_pkg::P2_SO3_PIN]  = serial_three_out_i;
    p2_alt_oe[mcuio_pkg::P2_SO3_PIN]   = 1'b1;
    p2_alt_sel[mcuio_pkg::P2_SO1_PIN]  = serial_one_en_i;                            // R11
    p2_alt_sel[mcuio_pkg::P2_SI1_PIN]  = serial_one_en_i;
    p2_alt_sel[mcuio_pkg::P2_SERIAL_ONE_CLOCK_PIN] = serial_one_en_i;
    p2_alt_out[mcuio_pkg::P2_SO1_PIN]  = serial_one_out_i;
    p2_alt_oe[mcuio_pkg::P2_SO1_PIN]   = 1'b1;
    p2_alt_out[mcuio_pkg::P2_SERIAL_ONE_CLOCK_PIN] = serial_one_clock_drv_i;
    p2_alt_oe[mcuio_pkg::P2_SERIAL_ONE_CLOCK_PIN]  = serial_one_clock_oe_i;
  end

  // ports 0, 2 and 5 are the bidirectional pins of this block
  mcuio_bidir_byte u_port0 (                                                          // R4
    .latch_i      (st_r.p0_data),
    .dir_i        (st_r.p0_dir),
    .pullup_sel_i (st_r.pu_zero),
    .alt_sel_i    (p0_alt_sel),
    .alt_out_i    (p0_alt_out),
    .alt_oe_i     (p0_alt_oe),
    .pin_i        (port0_pin_i),
    .pin_o        (port0_pin_o),
    .pin_oe_o     (port0_pin_oe_o),
    .pullup_en_o  (port0_pullup_en_o),
    .rd_o         (p0_rd)
  );

  mcuio_bidir_byte u_port2 (
    .latch_i      (st_r.p2_data),
    .dir_i        (st_r.p2_dir),
    .pullup_sel_i (st_r.pu_two),
    .alt_sel_i    (p2_alt_sel),
    .alt_out_i    (p2_alt_out),
    .alt_oe_i     (p2_alt_oe),
    .pin_i        (port2_pin_i),
    .pin_o        (port2_pin_o),
    .pin_oe_o     (port2_pin_oe_o),
    .pullup_en_o  (port2_pullup_en_o),
    .rd_o         (p2_rd)
  );

  // port 5: a latch bit at 1 drives high, at 0 the pin is released for input
  mcuio_bidir_byte u_port5 (                                                          // R15
    .latch_i      (st_r.p5_data),
    .dir_i        (st_r.p5_data),
    .pullup_sel_i (mcuio_pkg::BYTE_ZERO),
    .alt_sel_i    ({8{st_r.disp[mcuio_pkg::DISP_P5_BIT]}}),
    .alt_out_i    (display_driver_output_i[23:16]),
    .alt_oe_i     (mcuio_pkg::BYTE_ONES),
    .pin_i        (port5_pin_i),
    .pin_o        (port5_pin_o),
    .pin_oe_o     (port5_pin_oe_o),
    .pullup_en_o  (),
    .rd_o         (p5_rd)
  );

  mcuio_out_byte u_port3 (                                                            // R13
    .latch_i    (st_r.p3_data),
    .disp_sel_i (st_r.disp[mcuio_pkg::DISP_P3_BIT]),
    .disp_i     (display_driver_output_i[7:0]),
    .pin_o      (port3_pin_o)
  );

  mcuio_out_byte u_port4 (                                                            // R14
    .latch_i    (st_r.p4_data),
    .disp_sel_i (st_r.disp[mcuio_pkg::DISP_P4_BIT]),
    .disp_i     (display_driver_output_i[15:8]),
    .pin_o      (port4_pin_o)
  );

  // interrupt inputs see the pin only while their select is set; capture and serial inputs always see it
  assign ext_irq_zero_pin_o    = st_r.alt_sel[mcuio_pkg::ALT_IRQ0_BIT] & port0_pin_i[mcuio_pkg::ALT_IRQ0_BIT]; // R6
  assign ext_irq_one_pin_o     = st_r.alt_sel[mcuio_pkg::ALT_IRQ1_BIT] & port0_pin_i[mcuio_pkg::ALT_IRQ1_BIT]; // R6
  assign remote_capture_pin_o  = port0_pin_i[mcuio_pkg::P0_CAP_PIN];
  assign serial_three_clock_o  = port2_pin_i[mcuio_pkg::P2_SERIAL_THREE_CLOCK_PIN];
  assign serial_one_in_o       = port2_pin_i[mcuio_pkg::P2_SI1_PIN];
  assign serial_one_clock_o    = port2_pin_i[mcuio_pkg::P2_SERIAL_ONE_CLOCK_PIN];
  assign alt_function_select_o = st_r.alt_sel;

  assign s_axi_bvalid_o = st_r.bvalid;
  assign s_axi_bresp_o  = st_r.bresp;
  assign s_axi_rvalid_o = st_r.rvalid;
  assign s_axi_rresp_o  = st_r.rresp;
  assign s_axi_rdata_o  = {mcuio_pkg::RDATA_PAD, st_r.rdata};

  always_comb begin
    st_nxt = st_r;
    if (aw_fire) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr_i[mcuio_pkg::IDX_MSB:mcuio_pkg::IDX_LSB];
      st_nxt.aw_ok  = (s_axi_awaddr_i[mcuio_pkg::ADDR_W-1:mcuio_pkg::IDX_MSB+1] == '0);
    end
    if (w_fire) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_en   = s_axi_wstrb_i[0];
      st_nxt.w_data = s_axi_wdata_i[7:0];
      // lane 1 carries a bit mask for single-bit updates
      st_nxt.w_mask = s_axi_wstrb_i[1] ? s_axi_wdata_i[15:8] : mcuio_pkg::BYTE_ONES;  // R3
    end
    if (wr_fire) begin
      st_nxt.aw_got  = 1'b0;
      st_nxt.w_got   = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.wr_seen = 1'b1;
      st_nxt.bresp   = mcuio_pkg::RESP_OKAY;
      if (!st_r.aw_ok) begin
        st_nxt.bresp = mcuio_pkg::RESP_SLVERR;
      end else if (st_r.w_en) begin
        unique case (st_r.aw_idx)
          mcuio_pkg::IDX_P0_DATA:  st_nxt.p0_data = merge(st_r.p0_data, st_r.w_data, st_r.w_mask); // R5
          mcuio_pkg::IDX_P0_DIR:   st_nxt.p0_dir  = merge(st_r.p0_dir, st_r.w_data, st_r.w_mask);  // R5
          mcuio_pkg::IDX_P2_DATA:  st_nxt.p2_data = merge(st_r.p2_data, st_r.w_data, st_r.w_mask); // R10
          mcuio_pkg::IDX_P2_DIR:   st_nxt.p2_dir  = merge(st_r.p2_dir, st_r.w_data, st_r.w_mask);  // R10
          mcuio_pkg::IDX_P3_DATA:  st_nxt.p3_data = merge(st_r.p3_data, st_r.w_data, st_r.w_mask); // R13
          mcuio_pkg::IDX_P4_DATA:  st_nxt.p4_data = merge(st_r.p4_data, st_r.w_data, st_r.w_mask); // R14
          mcuio_pkg::IDX_P5_DATA:  st_nxt.p5_data = merge(st_r.p5_data, st_r.w_data, st_r.w_mask); // R15
          mcuio_pkg::IDX_ALT_SEL:  st_nxt.alt_sel = merge(st_r.alt_sel, st_r.w_data, st_r.w_mask)
                                                    & mcuio_pkg::ALT_MASK;                         // R8
          mcuio_pkg::IDX_DISP_SEL: st_nxt.disp    = merge(st_r.disp, st_r.w_data, st_r.w_mask)
                                                    & mcuio_pkg::DISP_MASK;
          mcuio_pkg::IDX_PU_ZERO:  st_nxt.pu_zero = merge(st_r.pu_zero, st_r.w_data, st_r.w_mask); // R7
          mcuio_pkg::IDX_PU_TWO:   st_nxt.pu_two  = merge(st_r.pu_two, st_r.w_data, st_r.w_mask);  // R12
          default:                 st_nxt.bresp   = mcuio_pkg::RESP_SLVERR;
        endcase
      end
    end
    if (st_r.bvalid && s_axi_bready_i) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready_i) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = mcuio_pkg::RESP_OKAY;
      st_nxt.rdata  = mcuio_pkg::BYTE_ZERO;
      if (!ar_ok) begin
        st_nxt.rresp = mcuio_pkg::RESP_SLVERR;
      end else begin
        unique case (ar_idx)
          mcuio_pkg::IDX_P0_DATA:  st_nxt.rdata = p0_rd;                                  // R18
          mcuio_pkg::IDX_P0_DIR:   st_nxt.rdata = st_r.p0_dir;
          mcuio_pkg::IDX_P2_DATA:  st_nxt.rdata = p2_rd;                                  // R18
          mcuio_pkg::IDX_P2_DIR:   st_nxt.rdata = st_r.p2_dir;
          mcuio_pkg::IDX_P3_DATA:  st_nxt.rdata = st_r.p3_data;
          mcuio_pkg::IDX_P4_DATA:  st_nxt.rdata = st_r.p4_data;
          mcuio_pkg::IDX_P5_DATA:  st_nxt.rdata = p5_rd;                                  // R16
          mcuio_pkg::IDX_ALT_SEL:  st_nxt.rdata = st_r.alt_sel;
          mcuio_pkg::IDX_DISP_SEL: st_nxt.rdata = st_r.disp;
          mcuio_pkg::IDX_PU_ZERO:  st_nxt.rdata = st_r.pu_zero;
          mcuio_pkg::IDX_PU_TWO:   st_nxt.rdata = st_r.pu_two;
          default:                 st_nxt.rresp = mcuio_pkg::RESP_SLVERR;
        endcase
      end
    end
  end

  // reset returns ports 0, 2 and 5 to input and every select to general i/o
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= ST_RST;                                                                 // R2
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  chk_dir_drives_pin: assert property ( // R1
    ((st_r.p0_dir & ~p0_alt_sel) & ~port0_pin_oe_o) == '0 && ((~st_r.p0_dir & ~p0_alt_sel) & port0_pin_oe_o) == '0)
    else $error("port 0 drive does not follow direction");

  chk_dir_reset_input: assert property ( // R2
    !st_r.wr_seen |-> (st_r.p0_dir == '0 && st_r.p2_dir == '0 && st_r.p5_data == '0 && st_r.alt_sel == '0))
    else $error("direction or select not cleared by reset");

  chk_bit_write_keep: assert property ( // R3
    wr_fire && st_r.aw_ok && st_r.w_en && st_r.aw_idx == mcuio_pkg::IDX_P0_DATA
    |=> ((st_r.p0_data ^ $past(st_r.p0_data)) & ~$past(st_r.w_mask)) == '0
        && ((st_r.p0_data ^ $past(st_r.w_data)) & $past(st_r.w_mask)) == '0)
    else $error("masked write changed wrong bits");

  chk_p4_byte_write: assert property ( // R14
    wr_fire && st_r.aw_ok && st_r.w_en && st_r.aw_idx == mcuio_pkg::IDX_P4_DATA && st_r.w_mask == '1
    |=> port4_pin_o == $past(st_r.w_data) || st_r.disp[mcuio_pkg::DISP_P4_BIT])
    else $error("port 4 byte write not on pins");

  chk_buzzer_override: assert property ( // R9
    st_r.alt_sel[mcuio_pkg::ALT_BUZ_BIT] |-> port0_pin_oe_o[mcuio_pkg::P0_BUZ_PIN]
                                             && port0_pin_o[mcuio_pkg::P0_BUZ_PIN] == buzzer_out_pin_i)
    else $error("buzzer not driven on its pin");

  chk_irq_input_only: assert property ( // R9
    st_r.alt_sel[mcuio_pkg::ALT_IRQ0_BIT] |-> !port0_pin_oe_o[mcuio_pkg::ALT_IRQ0_BIT]
                                              && ext_irq_zero_pin_o == port0_pin_i[mcuio_pkg::ALT_IRQ0_BIT])
    else $error("interrupt pin not released as input");

  chk_pullup_zero: assert property ( // R7
    port0_pullup_en_o == (st_r.pu_zero & ~port0_pin_oe_o))
    else $error("port 0 pull-up on a driven pin");

  chk_pullup_two: assert property ( // R12
    port2_pullup_en_o == (st_r.pu_two & ~port2_pin_oe_o))
    else $error("port 2 pull-up on a driven pin");

  chk_read_mix: assert property ( // R18
    ar_fire && ar_ok && ar_idx == mcuio_pkg::IDX_P2_DATA
    |=> s_axi_rvalid_o && s_axi_rdata_o[7:0] == (($past(port2_pin_i) & ~$past(st_r.p2_dir))
                                               | ($past(st_r.p2_data) & $past(st_r.p2_dir))))
    else $error("port 2 read mixes pin and latch wrongly");

  chk_p5_latch_drive: assert property ( // R15
    !st_r.disp[mcuio_pkg::DISP_P5_BIT] |-> port5_pin_oe_o == st_r.p5_data && port5_pin_o == st_r.p5_data)
    else $error("port 5 latch not driving pins");

  chk_write_answer: assert property ( // R3
    aw_fire && w_fire |-> ##1 !s_axi_bvalid_o ##1 s_axi_bvalid_o)
    else $error("write response not two cycles after handshake");

endmodule : mcuio_top

// ===== verif/mcuio_pin_model.sv
// mcuio_pin_model: board side of one bidirectional port.
// assumes oe high while the block drives; pull-ups win over the board level on undriven pins.
`timescale 1ns/100ps
module mcuio_pin_model (
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pu_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] lvl_o
);
  assign lvl_o = (oe_i & drv_i) | (~oe_i & (pu_i | ext_i));
endmodule : mcuio_pin_model

// ===== verif/mcuio_top_tb.sv
// mcuio_top_tb: register and pin scenarios of the i/o port block.
// assumes AXI4-Lite slave with byte address four times the register index.
`timescale 1ns/100ps
module mcuio_top_tb;
  logic        ref_clk_i = 0, arst_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0, buzzer_out_pin_i = 0, serial_three_en_i = 0;
  logic        serial_three_clock_drv_i = 0, serial_three_clock_oe_i = 0, serial_three_out_i = 0;
  logic        serial_one_en_i = 0, serial_one_out_i = 0, serial_one_clock_drv_i = 0, serial_one_clock_oe_i = 0;
  logic [11:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, rd;
  logic [3:0]  s_axi_wstrb_i = 0;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rsp;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [7:0]  port0_pin_i, port0_pin_o, port0_pin_oe_o, port0_pullup_en_o, port2_pin_i, port2_pin_o;
  logic [7:0]  port2_pin_oe_o, port2_pullup_en_o, port3_pin_o, port4_pin_o, port5_pin_i, port5_pin_o;
  logic [7:0]  port5_pin_oe_o, alt_function_select_o, e0 = 0;
  logic        ext_irq_zero_pin_o, ext_irq_one_pin_o, remote_capture_pin_o, serial_three_clock_o;
  logic        serial_one_in_o, serial_one_clock_o;
  logic [23:0] display_driver_output_i = 0;
  int          miscompares = 0, total_checks = 0, cyc = 0;
  mcuio_top dut (.*);
  mcuio_pin_model m0 (.drv_i(port0_pin_o), .oe_i(port0_pin_oe_o), .pu_i(port0_pullup_en_o), .ext_i(e0), .lvl_o(port0_pin_i));
  mcuio_pin_model m2 (.drv_i(port2_pin_o), .oe_i(port2_pin_oe_o), .pu_i(port2_pullup_en_o), .ext_i(e0), .lvl_o(port2_pin_i));
  mcuio_pin_model m5 (.drv_i(port5_pin_o), .oe_i(port5_pin_oe_o), .pu_i(8'h00), .ext_i(e0), .lvl_o(port5_pin_i));
  initial forever #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      test_done;
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // both channels offered together, each released at its own handshake edge
  task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [3:0] s);
    logic [2:0] h;
    s_axi_awaddr_i <= {2'b00, idx, 2'b00};
    s_axi_wdata_i <= {16'h0000, d};
    s_axi_wstrb_i <= s;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
    do begin
      @(negedge ref_clk_i);
      h = {s_axi_awready_o & s_axi_awvalid_i, s_axi_wready_o & s_axi_wvalid_i, s_axi_bvalid_o};
      if (h[0]) rsp = s_axi_bresp_o;
      @(posedge ref_clk_i);
      if (h[2]) s_axi_awvalid_i <= 1'b0;
      if (h[1]) s_axi_wvalid_i <= 1'b0;
      if (h[0]) s_axi_bready_i <= 1'b0;
    end while (!h[0]);
    // let one edge pass so the next call never re-drives bready in the same step
    @(posedge ref_clk_i);
  endtask : wr
  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    logic [1:0] h;
    s_axi_araddr_i <= {2'b00, idx, 2'b00};
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
    do begin
      @(negedge ref_clk_i);
      h = {s_axi_arready_o & s_axi_arvalid_i, s_axi_rvalid_o};
      if (h[0]) {rsp, rd} = {s_axi_rresp_o, s_axi_rdata_o};
      @(posedge ref_clk_i);
      if (h[1]) s_axi_arvalid_i <= 1'b0;
      if (h[0]) s_axi_rready_i <= 1'b0;
    end while (!h[0]);
    @(posedge ref_clk_i);
    chk(rd, exp);
  endtask : rc
  task automatic t_reset;
    rc(mcuio_pkg::IDX_P0_DIR, 0);
    rc(mcuio_pkg::IDX_P2_DIR, 0);
    rc(mcuio_pkg::IDX_ALT_SEL, 0);
    rc(mcuio_pkg::IDX_P4_DATA, 0);
    chk({port0_pin_oe_o, port2_pin_oe_o, port5_pin_oe_o}, 0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_port0;
    e0 <= 8'h0f;
    wr(mcuio_pkg::IDX_P0_DIR, 16'h0055, 4'h1);
    wr(mcuio_pkg::IDX_P0_DATA, 16'h00f0, 4'h1);
    chk(port0_pin_oe_o, 8'h55);
    rc(mcuio_pkg::IDX_P0_DATA, 8'h5a);
    wr(mcuio_pkg::IDX_PU_ZERO, 16'h00ff, 4'h1);
    chk(port0_pullup_en_o, 8'haa);
    wr(mcuio_pkg::IDX_P0_DATA, 16'h0101, 4'h3);
    rc(mcuio_pkg::IDX_P0_DATA, 8'hfb);
    $display("port zero test done");
  endtask : t_port0
  task automatic t_misc;
    buzzer_out_pin_i <= 1'b1;
    serial_one_en_i <= 1'b1;
    serial_one_out_i <= 1'b1;
    wr(mcuio_pkg::IDX_ALT_SEL, 16'h0005, 4'h1);
    chk({port0_pin_oe_o[7], port0_pin_o[7], port0_pin_oe_o[0], ext_irq_zero_pin_o}, 4'hd);
    wr(mcuio_pkg::IDX_P2_DIR, 16'h000f, 4'h1);
    rc(mcuio_pkg::IDX_P2_DIR, 8'h0f);
    chk({port2_pin_oe_o, port2_pin_o}, 16'h2f20);
    wr(mcuio_pkg::IDX_P3_DATA, 16'h00a5, 4'h1);
    chk(port3_pin_o, 8'ha5);
    wr(mcuio_pkg::IDX_P5_DATA, 16'h003c, 4'h1);
    chk(port5_pin_oe_o & port5_pin_o, 8'h3c);
    wr(mcuio_pkg::IDX_P5_DATA, 16'h0000, 4'h1);
    rc(mcuio_pkg::IDX_P5_DATA, 8'h0f);
    wr(8'hf8, 16'h00ff, 4'h1);
    chk(rsp, mcuio_pkg::RESP_SLVERR);
    $display("misc test done");
  endtask : t_misc
  initial begin
    repeat (20) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_reset;
    t_port0;
    t_misc;
    test_done;
  end
endmodule : mcuio_top_tb
